// [design/lebc_params.svh]
// Register offsets, field positions, reset values and timing counts.
`ifndef LEBC_PARAMS_SVH
`define LEBC_PARAMS_SVH

// ---------------------------------------------------------------------------
// Register byte addresses (the parity and reserved offsets lie inside the aligned word at 68)
// ---------------------------------------------------------------------------
`define LEBC_OFS_ERR_CTRL 8'h68
`define LEBC_OFS_PARITY 8'h6a
`define LEBC_OFS_RSVD_6B 8'h6b
`define LEBC_OFS_BUF_ALLOC 8'h6c
`define LEBC_OFS_MODE 8'h80
`define LEBC_OFS_STATUS 8'h84

// ---------------------------------------------------------------------------
// Field positions of the error reporting control register
// ---------------------------------------------------------------------------
`define LEBC_BIT_SERR_SEV 11
`define LEBC_BIT_CRC_MINOR 10
`define LEBC_BIT_CRC_MAJOR 9
`define LEBC_BIT_CHAIN_FLOOD 8
`define LEBC_BIT_CHAIN_MINOR 7
`define LEBC_BIT_CHAIN_MAJOR 6
`define LEBC_BIT_OVF_FLOOD 5
`define LEBC_BIT_OVF_MINOR 4
`define LEBC_BIT_OVF_MAJOR 3
`define LEBC_BIT_PROT_FLOOD 2
`define LEBC_BIT_PROT_MINOR 1
`define LEBC_BIT_PROT_MAJOR 0
`define LEBC_ERR_CTRL_MASK 16'h0fff
`define LEBC_ERR_CTRL_RST 16'h0000

// ---------------------------------------------------------------------------
// Parity enable and buffer allocation fields
// ---------------------------------------------------------------------------
`define LEBC_PARITY_MASK 8'h01
`define LEBC_PARITY_RST 8'h00
`define LEBC_BUF_ALLOC_MASK 16'h3f3f
`define LEBC_BUF_ALLOC_RST 16'h1515
`define LEBC_POS_P_WANT 12
`define LEBC_POS_NP_WANT 10
`define LEBC_POS_R_WANT 8
`define LEBC_POS_P_NEED 4
`define LEBC_POS_NP_NEED 2
`define LEBC_POS_R_NEED 0

// ---------------------------------------------------------------------------
// Timing: extra PCI clocks a packet is held while parity is watched
// ---------------------------------------------------------------------------
`define LEBC_PARITY_HOLD_CLKS 2

`endif

// [design/lebc_pkg.sv]
// Types shared by the link error and buffer control block.
package lebc_pkg;

  // -------------------------------------------------------------------------
  // Operating modes of the bridge
  // -------------------------------------------------------------------------
  typedef enum logic [1:0] {
    lebc_mode_single_primary = 2'h0,
    lebc_mode_dual_primary = 2'h1,
    lebc_mode_generic_single = 2'h2,
    lebc_mode_generic_dual = 2'h3
  } lebc_mode_type;

  // Error events from the upstream link, one-cycle pulses.
  typedef struct packed {
    logic crc;
    logic chain_end;
    logic overflow;
    logic protocol;
    logic serr;
  } lebc_err_evt_type;

  // Per-channel buffer targets, each a two-bit field.
  typedef struct packed {
    logic [1:0] posted;
    logic [1:0] nonposted;
    logic [1:0] response;
  } lebc_chan_type;

  // Packet handoff from the PCI side toward the upstream link.
  typedef struct packed {
    logic valid;
    logic data_error;
    logic [31:0] tag;
  } lebc_pkt_type;

  // Parity watch states, Gray coded.
  typedef enum logic [1:0] {
    lebc_pw_idle = 2'h0,
    lebc_pw_wait1 = 2'h1,
    lebc_pw_wait2 = 2'h3,
    lebc_pw_send = 2'h2
  } lebc_pw_state_type;

endpackage : lebc_pkg

// [design/lebc_err_router.sv]
// Maps link error events onto fatal, nonfatal and flood outputs.
`timescale 1ns/100ps
`include "lebc_params.svh"
module lebc_err_router (
  input wire logic [15:0] ctrl,
  input wire lebc_pkg::lebc_err_evt_type evt,
  input wire logic irq_gate,
  input wire logic active,
  output logic fatal,
  output logic nonfatal,
  output logic flood
);

  // Returns {fatal, nonfatal}; both enables set reports as fatal.
  function automatic logic [1:0] classify(input logic ev, input logic maj,
                                          input logic mnr);
    classify = {ev & maj, ev & mnr & ~maj};
  endfunction : classify

  logic [1:0] c_crc;
  logic [1:0] c_chn;
  logic [1:0] c_ovf;
  logic [1:0] c_prt;
  logic [1:0] c_srr;

  always_comb begin
    c_crc = classify(evt.crc, ctrl[`LEBC_BIT_CRC_MAJOR],
                     ctrl[`LEBC_BIT_CRC_MINOR]);
    c_chn = classify(evt.chain_end, ctrl[`LEBC_BIT_CHAIN_MAJOR],
                     ctrl[`LEBC_BIT_CHAIN_MINOR]);
    c_ovf = classify(evt.overflow, ctrl[`LEBC_BIT_OVF_MAJOR],
                     ctrl[`LEBC_BIT_OVF_MINOR]);
    c_prt = classify(evt.protocol, ctrl[`LEBC_BIT_PROT_MAJOR],
                     ctrl[`LEBC_BIT_PROT_MINOR]);
    c_srr = classify(evt.serr, ctrl[`LEBC_BIT_SERR_SEV],
                     ~ctrl[`LEBC_BIT_SERR_SEV]);
    fatal = active & irq_gate &
            (c_crc[1] | c_chn[1] | c_ovf[1] | c_prt[1] | c_srr[1]);
    nonfatal = active & irq_gate &
               (c_crc[0] | c_chn[0] | c_ovf[0] | c_prt[0] | c_srr[0]);
    flood = active &
            ((evt.chain_end & ctrl[`LEBC_BIT_CHAIN_FLOOD]) |
             (evt.overflow & ctrl[`LEBC_BIT_OVF_FLOOD]) |
             (evt.protocol & ctrl[`LEBC_BIT_PROT_FLOOD]));
  end

endmodule : lebc_err_router

// [design/lebc_parity_watch.sv]
// Holds each PCI to link packet two PCI clocks while parity is watched when enable is set; with enable clear it goes straight to send.
`timescale 1ns/100ps
`include "lebc_params.svh"
module lebc_parity_watch (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic enable,
  input wire logic pci_clk_en,
  input wire logic perr_seen,
  input wire lebc_pkg::lebc_pkt_type pkt_in,
  output logic pkt_in_ready,
  output lebc_pkg::lebc_pkt_type pkt_out,
  input wire logic pkt_out_ready
);

  typedef struct packed {
    lebc_pkg::lebc_pw_state_type st;
    logic rdy;
    lebc_pkg::lebc_pkt_type pkt;
  } lebc_pw_regs_type;

  lebc_pw_regs_type r_q;
  lebc_pw_regs_type r_d;

  always_comb begin
    r_d = r_q;
    case (r_q.st)
      lebc_pkg::lebc_pw_idle: begin
        if (pkt_in.valid) begin
          r_d.pkt = pkt_in;
          r_d.st = enable ? lebc_pkg::lebc_pw_wait1 :
                            lebc_pkg::lebc_pw_send;
        end
      end
      lebc_pkg::lebc_pw_wait1: begin
        if (perr_seen) begin
          r_d.pkt.data_error = 1'b1;
        end
        if (pci_clk_en) begin
          r_d.st = lebc_pkg::lebc_pw_wait2;
        end
      end
      lebc_pkg::lebc_pw_wait2: begin
        if (perr_seen) begin
          r_d.pkt.data_error = 1'b1;
        end
        if (pci_clk_en) begin
          r_d.st = lebc_pkg::lebc_pw_send;
        end
      end
      lebc_pkg::lebc_pw_send: begin
        if (pkt_out_ready) begin
          r_d.st = lebc_pkg::lebc_pw_idle;
          r_d.pkt.valid = 1'b0;
        end
      end
      default: begin
        r_d.st = lebc_pkg::lebc_pw_idle;
      end
    endcase
    // Handshake outputs are registered copies of the next state.
    r_d.rdy = (r_d.st == lebc_pkg::lebc_pw_idle);
    r_d.pkt.valid = (r_d.st == lebc_pkg::lebc_pw_send);
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      r_q <= '0;
      r_q.rdy <= 1'b1;
    end else begin
      r_q <= r_d;
    end
  end

  assign pkt_in_ready = r_q.rdy;
  assign pkt_out = r_q.pkt;

endmodule : lebc_parity_watch

// [design/lebc_top.sv]
// Link error reporting and receive buffer control registers.
// ---------------------------------------------------------------------------
// ---------------------------------------------------------------------------
//
// Our own choice: the Avalon-MM register port.
`timescale 1ns/100ps
`include "lebc_params.svh"
module lebc_top #(
  parameter int PCI_DIV = 6
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire lebc_pkg::lebc_mode_type mode,
  input wire logic system_error_irq_gate,
  input wire lebc_pkg::lebc_err_evt_type err_evt,
  input wire logic perr_seen,
  input wire lebc_pkg::lebc_pkt_type pkt_in,
  output logic pkt_in_ready,
  output lebc_pkg::lebc_pkt_type pkt_out,
  input wire logic pkt_out_ready,
  output logic fatal_irq,
  output logic nonfatal_irq,
  output logic sync_flood,
  output logic link_failed_flag,
  output lebc_pkg::lebc_chan_type target_released_bufs,
  output lebc_pkg::lebc_chan_type min_data_bufs
);

  // -------------------------------------------------------------------------
  // State
  // -------------------------------------------------------------------------
  typedef struct packed {
    logic [15:0] err_ctrl;
    logic parity_en;
    logic [15:0] buf_alloc;
    logic [31:0] rdata;
    logic ack;
    logic fatal;
    logic nonfatal;
    logic flood;
    logic link_failed;
    logic [7:0] div_cnt;
    logic pci_en;
    lebc_pkg::lebc_chan_type want;
    lebc_pkg::lebc_chan_type need;
  } lebc_regs_type;

  lebc_regs_type r_q;
  lebc_regs_type r_d;

  logic primary;
  logic rt_fatal;
  logic rt_nonfatal;
  logic rt_flood;
  logic pw_in_ready;
  lebc_pkg::lebc_pkt_type pw_out;

  // Merges a write into a register under byte enables and a writable mask.
  function automatic logic [15:0] wr16(input logic [15:0] old,
                                       input logic [15:0] wd,
                                       input logic [1:0] be,
                                       input logic [15:0] mask);
    logic [15:0] bm;
    bm = {{8{be[1]}}, {8{be[0]}}} & mask;
    wr16 = (old & ~bm) | (wd & bm);
  endfunction : wr16

  // Adds one to a two-bit count, giving a three-bit target.
  function automatic logic [2:0] plus1(input logic [1:0] f);
    plus1 = {1'b0, f} + 3'h1;
  endfunction : plus1

  assign primary = (mode == lebc_pkg::lebc_mode_single_primary) ||
                   (mode == lebc_pkg::lebc_mode_dual_primary);

  // -------------------------------------------------------------------------
  // Error routing and parity watch
  // -------------------------------------------------------------------------
  lebc_err_router u_router (
    .ctrl(r_q.err_ctrl),
    .evt(err_evt),
    .irq_gate(system_error_irq_gate),
    .active(primary),
    .fatal(rt_fatal),
    .nonfatal(rt_nonfatal),
    .flood(rt_flood)
  );

  lebc_parity_watch u_watch (
    .clock(clock),
    .sys_rst(sys_rst),
    .enable(r_q.parity_en & ~primary),
    .pci_clk_en(r_q.pci_en),
    .perr_seen(perr_seen),
    .pkt_in(pkt_in),
    .pkt_in_ready(pw_in_ready),
    .pkt_out(pw_out),
    .pkt_out_ready(pkt_out_ready)
  );

  // -------------------------------------------------------------------------
  // Next state
  // -------------------------------------------------------------------------
  always_comb begin
    r_d = r_q;
    r_d.ack = 1'b0;
    // PCI clock rate enable from the core clock.
    r_d.pci_en = 1'b0;
    if (r_q.div_cnt >= 8'(PCI_DIV - 1)) begin
      r_d.div_cnt = 8'h00;
      r_d.pci_en = 1'b1;
    end else begin
      r_d.div_cnt = r_q.div_cnt + 8'h01;
    end
    // Bus access completes one cycle after it is seen.
    if ((avs_read || avs_write) && !r_q.ack) begin
      r_d.ack = 1'b1;
      r_d.rdata = 32'h0000_0000;
      case (avs_address)
        `LEBC_OFS_ERR_CTRL: begin
          if (primary) begin
            r_d.rdata[15:0] = r_q.err_ctrl;
          end else begin
            r_d.rdata[16] = r_q.parity_en;
          end
        end
        `LEBC_OFS_BUF_ALLOC: begin
          r_d.rdata[15:0] = r_q.buf_alloc;
        end
        `LEBC_OFS_MODE: begin
          r_d.rdata[1:0] = mode;
        end
        `LEBC_OFS_STATUS: begin
          r_d.rdata[3:0] = {r_q.link_failed, r_q.flood, r_q.nonfatal,
                            r_q.fatal};
        end
        default: begin
          r_d.rdata = 32'h0000_0000;
        end
      endcase
    end
    // A write lands only at the edge where waitrequest is seen low.
    if (avs_write && r_q.ack) begin
      case (avs_address)
        `LEBC_OFS_ERR_CTRL: begin
          if (primary) begin
            r_d.err_ctrl = wr16(r_q.err_ctrl, avs_writedata[15:0],
                                avs_byteenable[1:0], `LEBC_ERR_CTRL_MASK);
          end else if (avs_byteenable[2]) begin
            r_d.parity_en = avs_writedata[16];
          end
        end
        `LEBC_OFS_BUF_ALLOC: begin
          r_d.buf_alloc = wr16(r_q.buf_alloc, avs_writedata[15:0],
                               avs_byteenable[1:0], `LEBC_BUF_ALLOC_MASK);
        end
        `LEBC_OFS_STATUS: begin
          if (avs_byteenable[0] && avs_writedata[3]) begin
            r_d.link_failed = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
    r_d.fatal = rt_fatal;
    r_d.nonfatal = rt_nonfatal;
    r_d.flood = rt_flood;
    if (rt_flood) begin
      r_d.link_failed = 1'b1;
    end
    r_d.want.posted = r_d.buf_alloc[`LEBC_POS_P_WANT +: 2];
    r_d.want.nonposted = r_d.buf_alloc[`LEBC_POS_NP_WANT +: 2];
    r_d.want.response = r_d.buf_alloc[`LEBC_POS_R_WANT +: 2];
    r_d.need.posted = r_d.buf_alloc[`LEBC_POS_P_NEED +: 2];
    r_d.need.nonposted = r_d.buf_alloc[`LEBC_POS_NP_NEED +: 2];
    r_d.need.response = r_d.buf_alloc[`LEBC_POS_R_NEED +: 2];
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      r_q <= '0;
      r_q.err_ctrl <= `LEBC_ERR_CTRL_RST;
      r_q.buf_alloc <= `LEBC_BUF_ALLOC_RST;
      r_q.want <= 6'h15;
      r_q.need <= 6'h15;
    end else begin
      r_q <= r_d;
    end
  end

  // -------------------------------------------------------------------------
  // Outputs
  // -------------------------------------------------------------------------
  assign avs_readdata = r_q.rdata;
  assign avs_waitrequest = ~r_q.ack;
  assign fatal_irq = r_q.fatal;
  assign nonfatal_irq = r_q.nonfatal;
  assign sync_flood = r_q.flood;
  assign link_failed_flag = r_q.link_failed;
  assign target_released_bufs = r_q.want;
  assign min_data_bufs = r_q.need;
  assign pkt_in_ready = pw_in_ready;
  assign pkt_out = pw_out;

  // Unused high bits of plus1 keep the helper for buffer logic users.
  logic [2:0] unused_p;
  assign unused_p = plus1(r_q.want.posted);

endmodule : lebc_top

// [sim/lebc_link_partner.sv]
// Upstream link partner that takes packets and drives parity errors.
`timescale 1ns/100ps
module lebc_link_partner (
  input wire logic clock,
  input wire logic sys_rst,
  input wire lebc_pkg::lebc_pkt_type pkt_out,
  input wire logic [3:0] stall,
  input wire logic perr_req,
  output logic pkt_out_ready,
  output logic perr_seen,
  output lebc_pkg::lebc_pkt_type got
);
  logic [3:0] wait_q;
  // Ready rises only after an offered packet has waited the stall count.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      wait_q <= 4'h0;
      pkt_out_ready <= 1'b0;
      got <= '0;
    end else begin
      pkt_out_ready <= 1'b0;
      if (pkt_out.valid && pkt_out_ready) begin
        got <= pkt_out;
        wait_q <= 4'h0;
      end else if (pkt_out.valid && wait_q >= stall) begin
        pkt_out_ready <= 1'b1;
      end else if (pkt_out.valid) begin
        wait_q <= wait_q + 4'h1;
      end
    end
  end
  assign perr_seen = perr_req;
endmodule : lebc_link_partner

// [sim/lebc_top_asserts.sv]
// Concurrent checks on the ports of the link error and buffer block.
`timescale 1ns/100ps
module lebc_top_asserts #(
  parameter int PCI_DIV = 6
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire lebc_pkg::lebc_mode_type mode,
  input wire logic system_error_irq_gate,
  input wire lebc_pkg::lebc_err_evt_type err_evt,
  input wire logic perr_seen,
  input wire lebc_pkg::lebc_pkt_type pkt_in,
  input wire logic pkt_in_ready,
  input wire lebc_pkg::lebc_pkt_type pkt_out,
  input wire logic pkt_out_ready,
  input wire logic fatal_irq,
  input wire logic nonfatal_irq,
  input wire logic sync_flood,
  input wire logic link_failed_flag,
  input wire lebc_pkg::lebc_chan_type target_released_bufs,
  input wire lebc_pkg::lebc_chan_type min_data_bufs
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);
  ack_one_cycle_a: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("access not answered in one cycle");
  ack_stands_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  ack_needs_req_a: assert property (
    !avs_waitrequest |-> $past(avs_read || avs_write))
    else $error("answer without a request");
  irq_gated_a: assert property (
    fatal_irq || nonfatal_irq |->
    $past(system_error_irq_gate) && !$past(mode[1]))
    else $error("interrupt while gated or in generic mode");
  flood_cause_a: assert property (
    sync_flood |-> !$past(mode[1]) && $past(err_evt.chain_end ||
    err_evt.overflow || err_evt.protocol))
    else $error("flood without a cause");
  flag_with_flood_a: assert property (
    $rose(link_failed_flag) |-> sync_flood)
    else $error("link failure flag without flood");
  irq_cause_a: assert property (
    fatal_irq |-> $past(err_evt) != '0)
    else $error("fatal interrupt without an event");
  out_holds_a: assert property (
    pkt_out.valid && !pkt_out_ready |=> pkt_out.valid && $stable(pkt_out))
    else $error("packet dropped or changed before ready");
  in_busy_a: assert property (
    pkt_in.valid && pkt_in_ready |=> !pkt_in_ready)
    else $error("new packet taken while busy");
  out_bounded_a: assert property (
    pkt_in.valid && pkt_in_ready |-> ##[1:40] pkt_out.valid)
    else $error("packet never offered upstream");
  bufs_by_write_a: assert property (
    !$stable({target_released_bufs, min_data_bufs}) |->
    $past(avs_write && !avs_waitrequest))
    else $error("buffer fields changed without a write");
endmodule : lebc_top_asserts

bind lebc_top lebc_top_asserts #(.PCI_DIV(PCI_DIV)) lebc_top_asserts_inst (
  .clock, .sys_rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
  .avs_byteenable, .avs_readdata, .avs_waitrequest, .mode,
  .system_error_irq_gate, .err_evt, .perr_seen, .pkt_in, .pkt_in_ready,
  .pkt_out, .pkt_out_ready, .fatal_irq, .nonfatal_irq, .sync_flood,
  .link_failed_flag, .target_released_bufs, .min_data_bufs);

// [sim/link_error_and_buffer_ctrl_test.sv]
// Self-checking bench for the link error and buffer control block.
`timescale 1ns/100ps
module link_error_and_buffer_ctrl_test;
  localparam int PD = 2;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  lebc_pkg::lebc_mode_type mode = lebc_pkg::lebc_mode_single_primary;
  logic system_error_irq_gate = 1'b1;
  lebc_pkg::lebc_err_evt_type err_evt = '0;
  lebc_pkg::lebc_pkt_type pkt_in = '0;
  lebc_pkg::lebc_pkt_type pkt_out, got;
  logic perr_req = 1'b0;
  logic [3:0] stall = 4'h3;
  logic perr_seen, pkt_in_ready, pkt_out_ready, fatal_irq, nonfatal_irq;
  logic sync_flood, link_failed_flag;
  lebc_pkg::lebc_chan_type target_released_bufs, min_data_bufs;
  int error_cnt = 0;
  int compares = 0;

  always #2.5 clock = ~clock;

  lebc_top #(.PCI_DIV(PD)) lebc_top_inst (.clock, .sys_rst, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
    .avs_waitrequest, .mode, .system_error_irq_gate, .err_evt, .perr_seen,
    .pkt_in, .pkt_in_ready, .pkt_out, .pkt_out_ready, .fatal_irq,
    .nonfatal_irq, .sync_flood, .link_failed_flag, .target_released_bufs,
    .min_data_bufs);

  lebc_link_partner lebc_link_partner_inst (.clock, .sys_rst, .pkt_out,
    .stall, .perr_req, .pkt_out_ready, .perr_seen, .got);

  task automatic wrap_up();
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up

  task automatic check(input logic [31:0] g, e);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask : check

  task automatic timeout();
    error_cnt++;
    $display("[FAIL] %0t wait ran out", $time);
    wrap_up();
  endtask : timeout

  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [3:0] be,
                     output logic [31:0] r);
    int n;
    @(posedge clock);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_write <= w;
    avs_read <= !w;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n == 50) timeout();
    r = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] be = 4'hf);
    logic [31:0] x;
    bus(1'b1, a, d, be, x);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] x;
    bus(1'b0, a, 32'h0, 4'hf, x);
    check(x, e);
  endtask : rd

  task automatic fire(input logic [4:0] ev, input logic [2:0] e);
    @(posedge clock);
    err_evt <= ev;
    @(posedge clock);
    err_evt <= '0;
    #1 check(32'({fatal_irq, nonfatal_irq, sync_flood}), 32'(e));
  endtask : fire

  task automatic send(input logic [31:0] tag, input logic perr, err,
                      input int lo, hi);
    int n;
    @(posedge clock);
    perr_req <= perr;
    pkt_in <= '{1'b1, 1'b0, tag};
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pkt_in_ready !== 1'b1 && n < 50);
    if (n == 50) timeout();
    pkt_in <= '0;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pkt_out.valid !== 1'b1 && n < 50);
    check(32'(n >= lo && n <= hi), 32'h1);
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (got.tag !== tag && n < 50);
    if (n == 50) timeout();
    perr_req <= 1'b0;
    check(32'(got.data_error), 32'(err));
  endtask : send

  task automatic t_reset();
    rd(8'h68, 32'h0);
    rd(8'h6c, 32'h1515);
    rd(8'h70, 32'h0);
    check(32'({target_released_bufs, min_data_bufs}), 32'h555);
  endtask : t_reset

  task automatic t_route();
    for (int b = 0; b < 11; b++) begin
      wr(8'h68, 32'h1 << b);
      fire(5'h2 << (b / 3), 3'h4 >> (b % 3));
    end
    check(32'(link_failed_flag), 32'h1);
    wr(8'h84, 32'h8);
    @(posedge clock);
    check(32'(link_failed_flag), 32'h0);
    wr(8'h68, 32'h800);
    fire(5'h1, 3'h4);
    wr(8'h68, 32'h0);
    fire(5'h1, 3'h2);
    wr(8'h68, 32'hffff);
    rd(8'h68, 32'h0fff);
    fire(5'h2, 3'h5);
    @(posedge clock);
    system_error_irq_gate <= 1'b0;
    fire(5'h10, 3'h0);
    @(posedge clock);
    system_error_irq_gate <= 1'b1;
  endtask : t_route

  task automatic t_modes();
    for (int m = 0; m < 4; m++) begin
      @(posedge clock);
      mode <= lebc_pkg::lebc_mode_type'(m);
      wr(8'h68, 32'h1_0001);
      rd(8'h68, m > 1 ? 32'h1_0000 : 32'h1);
      fire(5'h2, m > 1 ? 3'h0 : 3'h4);
    end
  endtask : t_modes

  task automatic t_bufs();
    wr(8'h6c, 32'hffff_ffff);
    rd(8'h6c, 32'h3f3f);
    wr(8'h6c, 32'h0, 4'h1);
    rd(8'h6c, 32'h3f00);
    check(32'({target_released_bufs, min_data_bufs}), 32'hfc0);
  endtask : t_bufs

  task automatic t_parity();
    send(32'ha1, 1'b0, 1'b0, 2 * PD, 2 * PD + 4);
    send(32'hb2, 1'b1, 1'b1, 2 * PD, 2 * PD + 4);
    wr(8'h68, 32'h0);
    @(posedge clock);
    stall <= 4'h0;
    send(32'hc3, 1'b1, 1'b0, 1, 2);
  endtask : t_parity

  initial begin
    repeat (4) @(posedge clock);
    sys_rst <= 1'b0;
    t_reset();
    t_route();
    t_modes();
    t_bufs();
    t_parity();
    wrap_up();
  end
endmodule : link_error_and_buffer_ctrl_test
